// [dv/audio_port_monitor.sv]
`timescale 1ns/10ps
module audio_port_monitor
    import audio_port_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] pin_func_en,
    input wire logic [2*NPINS-1:0] gpio_mode,
    input wire logic rx_sync_direction,
    input wire logic rx_clock_direction,
    input wire logic tx_sync_direction,
    input wire logic [N_TX-1:0] tx_enable,
    input wire logic second_port_enable,
    input wire logic second_gpio_enable,
    input wire logic [N_SHARED-1:0] sp_data_oe,
    input wire logic rx_valid,
    input wire logic tx_ready
);
    // Pin enables are registered, so each check but the reset one looks one edge on.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_RESET_OFF: assert property ($rose(nrst) |-> pin_oe == '0)
        else $error("pin driven after reset");
    AST_GPIO_DIR: assert property (!pin_func_en[2]
        |=> pin_oe[2] == ($past(gpio_mode[5:4]) == 2'h2)) else $error("gpio drive wrong");
    AST_RXCK_DIR: assert property (pin_func_en[0]
        |=> pin_oe[0] == $past(rx_clock_direction)) else $error("rx clock dir wrong");
    AST_RXFS_DIR: assert property (pin_func_en[1]
        |=> pin_oe[1] == $past(rx_sync_direction)) else $error("rx sync dir wrong");
    AST_TXFS_DIR: assert property (pin_func_en[4]
        |=> pin_oe[4] == $past(tx_sync_direction)) else $error("tx sync dir wrong");
    AST_TX0_OUT: assert property (pin_func_en[11] && !second_port_enable && !second_gpio_enable
        |=> pin_oe[11] == $past(tx_enable[0])) else $error("tx0 pin drive wrong");
    AST_SHARED_OE: assert property (second_port_enable && !second_gpio_enable
        |=> pin_oe[11:8] == $past(sp_data_oe)) else $error("shared pins kept");
    AST_RX_PULSE: assert property (rx_valid |=> !rx_valid)
        else $error("rx pulse too long");
    // Main scenarios: word received, buffer full, pins handed over.
    cover property (rx_valid);
    cover property (!tx_ready);
    cover property (second_port_enable && pin_oe[11]);
endmodule : audio_port_monitor

bind audio_serial_port audio_port_monitor u_audio_port_monitor (.*);

// [dv/codec_model.sv]
`timescale 1ns/10ps
// Codec feeding the receiver; bit clock rests low between words.
module codec_model (
    output logic bck,
    output logic fs,
    output logic sd
);
    initial begin
        bck = 1'b0;
        fs = 1'b0;
        sd = 1'b0;
    end
    // One 800 ns bit period.
    task automatic tick();
        #400 bck = 1'b1;
        #400 bck = 1'b0;
    endtask : tick
    // Sync for one rising edge, then the word MSB first.
    task automatic send(input logic [23:0] w);
        #37 fs = 1'b1;
        tick();
        fs = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sd = w[i];
            tick();
        end
        sd = ~sd; // A released line must not keep showing the last bit.
    endtask : send
endmodule : codec_model

// [dv/tb.sv]
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
`define WAIT(c) for (k = 0; k < 1000 && !(c); k++) @(negedge clk); \
    if (k >= 1000) begin err_count++; conclude(); end
module tb
    import audio_port_pkg::*;
;
    typedef struct packed {
        logic [11:0] fen;
        logic [23:0] gm;
        logic [5:0] dir;
        logic [35:0] exp;
    } row_t;
    // Row: pin config, then the expected oe, pin_o and gpio_in.
    row_t rows [6] = '{'{12'h000, 24'hAAAAAA, 6'h00, 36'hFFF5A5000},
        '{12'h000, 24'hCCCCCC, 6'h00, 36'h000000000}, '{12'hFFF, 24'h000000, 6'h3C, 36'h01B000000},
        '{12'h000, 24'hAAAAAA, 6'h02, 36'hAFF2A5000}, '{12'h000, 24'hAAAAAA, 6'h01, 36'h5FF1A5000},
        '{12'h000, 24'h555555, 6'h00, 36'h000000A1C}};
    logic [23:0] wd [2] = '{24'hA5C396, 24'h5A3C69};
    logic clk = 1'b0, nrst = 1'b0, rx_enable = 1'b1, tx_valid = 1'b0, sync_mode_select = 1'b0;
    logic tx_buffer_enable_select = 1'b0, rx_sync_direction = 1'b0, rx_clock_direction = 1'b0;
    logic tx_sync_direction = 1'b0, tx_clock_direction = 1'b0, output_flag_zero = 1'b0;
    logic output_flag_one = 1'b0, second_port_enable = 1'b0, second_gpio_enable = 1'b0;
    logic [11:0] pin_func_en = 12'h000, gpio_out = 12'h5A5, ext_lvl = 12'hA5C;
    logic [23:0] gpio_mode = 24'h000000, tx_data = 24'hF0F0F0;
    logic [3:0] sp_data_o = 4'h6, sp_data_oe = 4'hA, sp_gpio_out = 4'h3, data_rx_sel = 4'h1;
    logic [7:0] sp_gpio_mode = 8'h22;
    logic [5:0] tx_enable = 6'h00;
    logic [11:0] pin_i, pin_o, pin_oe, gpio_in;
    logic [23:0] rx_data;
    logic rx_valid, tx_ready, bck, fs, sd;
    int err_count = 0, checks = 0, k, n = 0;
    // Wire level: device where it drives, else codec or board.
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & {ext_lvl[11:7], sd, ext_lvl[5:2], fs, bck});
    always #50 clk = ~clk;
    audio_serial_port u_audio_serial_port (.clk, .nrst, .pin_i, .pin_o, .pin_oe, .pin_func_en,
        .gpio_mode, .gpio_out, .gpio_in, .sync_mode_select, .network_mode(1'b0),
        .tx_buffer_enable_select, .rx_sync_direction, .rx_clock_direction, .tx_sync_direction,
        .tx_clock_direction, .rx_hf_direction(1'b0), .tx_hf_direction(1'b0),
        .rx_hf_source_sel(1'b0), .tx_hf_source_sel(1'b0), .output_flag_zero, .output_flag_one,
        .input_flag_zero(), .input_flag_one(), .tx_enable, .rx_enable, .data_rx_sel, .tx_data,
        .tx_valid, .tx_ready, .rx_data, .rx_valid, .second_port_enable, .second_gpio_enable,
        .sp_data_o, .sp_data_oe, .sp_data_i(), .sp_gpio_mode, .sp_gpio_out, .sp_gpio_in());
    codec_model u_codec_model (.bck, .fs, .sd);
    task automatic conclude();
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (11) @(posedge clk);
        @(negedge clk);
        `CHK("pin_oe", 12'h000, pin_oe)
        @(posedge clk) nrst <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clk) {pin_func_en, gpio_mode, rx_sync_direction, rx_clock_direction,
                tx_sync_direction, tx_clock_direction, second_port_enable,
                second_gpio_enable} <= rows[i][77:36];
            repeat (5) @(negedge clk);
            `CHK("pin_oe", rows[i].exp[35:24], pin_oe)
            if (rows[i].fen == 12'h000) `CHK("pin_o", rows[i].exp[23:12], pin_o & rows[i].exp[35:24])
            `CHK("gpio_in", rows[i].exp[11:0], gpio_in)
        end
        // Transmitters off: the buffer fills until it refuses.
        @(posedge clk) pin_func_en <= 12'hFFF;
        tx_valid <= 1'b1;
        repeat (40) @(negedge clk) n += int'(tx_ready === 1'b1);
        `CHK("words taken", 33, n)
        @(posedge clk) tx_valid <= 1'b0;
        foreach (wd[j]) begin
            fork
                u_codec_model.send(wd[j]);
                begin
                    `WAIT(rx_valid === 1'b1)
                end
            join
            `CHK("rx_data", wd[j], rx_data)
        end
        // Sync mode with flags out; a flag change must wait for the next frame.
        @(posedge clk) {sync_mode_select, rx_sync_direction, rx_clock_direction} <= 3'h7;
        {tx_sync_direction, tx_clock_direction, output_flag_zero, tx_enable} <= 9'h1C1;
        repeat (2) @(negedge clk);
        `WAIT(pin_o[0] === 1'b1)
        `CHK("flag one", 1'b0, pin_o[1])
        @(posedge clk) {output_flag_zero, output_flag_one} <= 2'h1;
        repeat (10) @(negedge clk);
        `CHK("flag zero held", 1'b1, pin_o[0])
        `WAIT(pin_o[1] === 1'b1)
        `CHK("flag zero", 1'b0, pin_o[0])
        `WAIT(tx_ready === 1'b1)
        `CHK("tx0 drive", 1'b1, pin_oe[11])
        conclude();
    end
endmodule : tb

// [rtl/audio_port_pkg.sv]
// Contract
// - Receive fast clock input replaces core clock.
// - Transmit fast clock input replaces core clock.
// - Async mode: receive sync frames receivers.
// - Sync mode: receive sync is flag or enable.
// - Flag one direction follows receive sync direction.
// - Output flag one updates on frame/slot.
// - Input flag one captured on frame/slot.
// - Transmit sync frames both, or transmitters only.
// - Transmit sync direction from its control bit.
// - Receive bit clock async; flag zero sync.
// - Flag zero direction follows receive clock direction.
// - Flag zero out and in, frame/slot aligned.
// - Transmit bit clock serves both in sync.
// - Four data pins: transmitter or receiver; only the first one is read as receive data.
// - Transmitters one and zero output only.
// - Second port takes four shared data pins.
// - Second port GPIO takes pins eight-eleven.
// - GPIO pins: input, output or disconnected.
// - Reset leaves every pin disconnected.
package audio_port_pkg;

    localparam int NPINS = 12;
    localparam int PIN_RX_BCK = 0;
    localparam int PIN_RX_FS = 1;
    localparam int PIN_HF_RX = 2;
    localparam int PIN_TX_BCK = 3;
    localparam int PIN_TX_FS = 4;
    localparam int PIN_HF_TX = 5;
    localparam int PIN_DATA_LO = 6;
    localparam int PIN_TX1 = 10;
    localparam int PIN_TX0 = 11;
    localparam int SHARED_LO = 8;
    localparam int N_SHARED = 4;
    localparam int N_DUAL = 4;
    localparam int N_TX = 6;
    localparam int TX1_IDX = 1;
    localparam int TX0_IDX = 0;

    localparam logic [1:0] GPIO_OFF = 2'h0;
    localparam logic [1:0] GPIO_IN = 2'h1;
    localparam logic [1:0] GPIO_OUT = 2'h2;

    localparam int WORD_BITS = 24;
    localparam int BIT_W = 5;
    localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(WORD_BITS - 1);
    localparam logic [BIT_W-1:0] CNT_IDLE = BIT_W'(WORD_BITS);
    localparam int SLOTS = 2;
    localparam int SLOT_W = 1;
    localparam logic [SLOT_W-1:0] LAST_SLOT = SLOT_W'(SLOTS - 1);
    localparam int FIFO_DEPTH = 32;

    localparam int CLK_PERIOD_NS = 100;
    localparam int BCK_PERIOD_NS = 800;
    localparam int BCK_HALF_TICKS = (BCK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 3;
    localparam logic [DIV_W-1:0] LAST_DIV = DIV_W'(BCK_HALF_TICKS - 1);

    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_WAIT = 2'h1,
        TX_SHIFT = 2'h3
    } tx_state_t;

    // True when a GPIO mode drives its pin.
    function automatic logic gpio_drives(input logic [1:0] mode);
        return mode == GPIO_OUT;
    endfunction : gpio_drives

    // True when a GPIO mode reads its pin.
    function automatic logic gpio_reads(input logic [1:0] mode);
        return mode == GPIO_IN;
    endfunction : gpio_reads

endpackage : audio_port_pkg

// [rtl/audio_serial_port.sv]
`timescale 1ns/10ps
module audio_serial_port
    import audio_port_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [NPINS-1:0] pin_i,
    output logic [NPINS-1:0] pin_o,
    output logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] pin_func_en,
    input wire logic [2*NPINS-1:0] gpio_mode,
    input wire logic [NPINS-1:0] gpio_out,
    output logic [NPINS-1:0] gpio_in,
    input wire logic sync_mode_select,
    input wire logic network_mode,
    input wire logic tx_buffer_enable_select,
    input wire logic rx_sync_direction,
    input wire logic rx_clock_direction,
    input wire logic tx_sync_direction,
    input wire logic tx_clock_direction,
    input wire logic rx_hf_direction,
    input wire logic tx_hf_direction,
    input wire logic rx_hf_source_sel,
    input wire logic tx_hf_source_sel,
    input wire logic output_flag_zero,
    input wire logic output_flag_one,
    output logic input_flag_zero,
    output logic input_flag_one,
    input wire logic [N_TX-1:0] tx_enable,
    input wire logic rx_enable,
    input wire logic [N_DUAL-1:0] data_rx_sel,
    input wire logic [WORD_BITS-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [WORD_BITS-1:0] rx_data,
    output logic rx_valid,
    input wire logic second_port_enable,
    input wire logic second_gpio_enable,
    input wire logic [N_SHARED-1:0] sp_data_o,
    input wire logic [N_SHARED-1:0] sp_data_oe,
    output logic [N_SHARED-1:0] sp_data_i,
    input wire logic [2*N_SHARED-1:0] sp_gpio_mode,
    input wire logic [N_SHARED-1:0] sp_gpio_out,
    output logic [N_SHARED-1:0] sp_gpio_in
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    ////////////////////////////////////////////////////////////////////////

    logic [NPINS-1:0] sync1_r;
    logic [NPINS-1:0] sync2_r;
    logic [NPINS-1:0] pin_s;
    logic hf_div_r;
    logic [1:0] hf_prev_r;
    logic rx_hf_edge;
    logic tx_hf_edge;
    logic rx_tick;
    logic tx_tick;
    logic sync_on;

    logic tx_bck;
    logic tx_fs;
    logic tx_rise;
    logic tx_fall;
    logic tx_word;
    logic tx_frame;
    logic rx_bck;
    logic rx_fs;
    logic rx_rise;
    logic rx_fall;
    logic rx_word;
    logic rx_frame;

    logic flag_evt;
    logic flag0_in_mode;
    logic flag1_in_mode;
    logic of0_r;
    logic of1_r;
    logic if0_r;
    logic if1_r;

    tx_state_t tx_state_r;
    tx_state_t tx_state_nxt;
    logic [WORD_BITS-1:0] tx_sh_r;
    logic [WORD_BITS-1:0] tx_sh_nxt;
    logic tx_any;
    logic tx_load;
    logic tx_bit;
    logic tx_active;

    logic rcv_rise;
    logic rcv_word;
    logic rcv_on;
    logic rcv_bit;
    logic [BIT_W-1:0] rx_cnt_r;
    logic [WORD_BITS-1:0] rx_sh_r;
    logic [WORD_BITS-1:0] rx_data_r;
    logic rx_valid_r;

    logic [NPINS-1:0] fn_o;
    logic [NPINS-1:0] fn_oe;
    logic [NPINS-1:0] pin_o_nxt;
    logic [NPINS-1:0] pin_oe_nxt;
    logic [NPINS-1:0] gpio_in_nxt;
    logic [NPINS-1:0] pin_o_r;
    logic [NPINS-1:0] pin_oe_r;
    logic [NPINS-1:0] gpio_in_r;
    logic [N_SHARED-1:0] sp_gpio_in_r;
    logic [N_SHARED-1:0] sp_data_i_r;
    logic shared_taken;

    stream_if #(.WIDTH(WORD_BITS)) fifo_in ();
    stream_if #(.WIDTH(WORD_BITS)) fifo_out ();

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and the fast clocks.
    ////////////////////////////////////////////////////////////////////////

    // Every pin crosses two flops; only the second stage is read.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
        end
    end

    assign pin_s = sync2_r;
    assign sync_on = sync_mode_select;

    // Fast clock output is the core clock halved.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hf_div_r <= 1'b0;
            hf_prev_r <= 2'h0;
        end else begin
            hf_div_r <= ~hf_div_r;
            hf_prev_r <= {pin_s[PIN_HF_TX], pin_s[PIN_HF_RX]};
        end
    end

    assign rx_hf_edge = pin_s[PIN_HF_RX] & ~hf_prev_r[0];
    assign tx_hf_edge = pin_s[PIN_HF_TX] & ~hf_prev_r[1];
    assign rx_tick = (rx_hf_source_sel & ~rx_hf_direction) ? rx_hf_edge : 1'b1;
    assign tx_tick = (tx_hf_source_sel & ~tx_hf_direction) ? tx_hf_edge : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Bit clock and frame timing for each direction.
    ////////////////////////////////////////////////////////////////////////

    bit_timing tx_eng (
        .clk(clk),
        .nrst(nrst),
        .tick(tx_tick),
        .bck_dir_out(tx_clock_direction),
        .fs_dir_out(tx_sync_direction),
        .bck_pin(pin_s[PIN_TX_BCK]),
        .fs_pin(pin_s[PIN_TX_FS]),
        .bck_out(tx_bck),
        .fs_out(tx_fs),
        .rise(tx_rise),
        .fall(tx_fall),
        .word_start(tx_word),
        .frame_start(tx_frame)
    );

    bit_timing rx_eng (
        .clk(clk),
        .nrst(nrst),
        .tick(rx_tick),
        .bck_dir_out(rx_clock_direction),
        .fs_dir_out(rx_sync_direction),
        .bck_pin(pin_s[PIN_RX_BCK]),
        .fs_pin(pin_s[PIN_RX_FS]),
        .bck_out(rx_bck),
        .fs_out(rx_fs),
        .rise(rx_rise),
        .fall(rx_fall),
        .word_start(rx_word),
        .frame_start(rx_frame)
    );

    ////////////////////////////////////////////////////////////////////////
    // Serial flags, timed by the transmit frame, or by each transmit slot in network mode.
    ////////////////////////////////////////////////////////////////////////

    assign flag_evt = network_mode ? tx_word : tx_frame;
    assign flag0_in_mode = sync_on & ~rx_clock_direction;
    assign flag1_in_mode = sync_on & ~tx_buffer_enable_select & ~rx_sync_direction;

    // Flags move only at the event, so the pin never glitches mid-slot.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            of0_r <= 1'b0;
            of1_r <= 1'b0;
            if0_r <= 1'b0;
            if1_r <= 1'b0;
        end else if (flag_evt) begin
            of0_r <= output_flag_zero;
            of1_r <= output_flag_one;
            if0_r <= flag0_in_mode ? pin_s[PIN_RX_BCK] : if0_r;
            if1_r <= flag1_in_mode ? pin_s[PIN_RX_FS] : if1_r;
        end
    end

    assign input_flag_zero = if0_r;
    assign input_flag_one = if1_r;

    ////////////////////////////////////////////////////////////////////////
    // Transmit path: buffer, state machine and shifter.
    ////////////////////////////////////////////////////////////////////////

    assign fifo_in.valid = tx_valid;
    assign fifo_in.data = tx_data;
    assign tx_ready = fifo_in.ready;

    word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_s(fifo_in.snk),
        .out_s(fifo_out.src)
    );

    assign tx_any = |tx_enable;
    assign tx_load = tx_word & tx_any & (tx_state_r != TX_IDLE);
    assign fifo_out.ready = tx_load;
    assign tx_active = tx_state_r == TX_SHIFT;
    assign tx_bit = tx_sh_r[WORD_BITS-1];

    // An empty buffer at a slot start sends a zero word, not stale data.
    always_comb begin
        tx_state_nxt = tx_state_r;
        case (tx_state_r)
            TX_IDLE: begin
                if (tx_any) begin
                    tx_state_nxt = TX_WAIT;
                end
            end
            TX_WAIT, TX_SHIFT: begin
                if (!tx_any) begin
                    tx_state_nxt = TX_IDLE;
                end else if (tx_word) begin
                    tx_state_nxt = fifo_out.valid ? TX_SHIFT : TX_WAIT;
                end
            end
            default: begin
                tx_state_nxt = TX_IDLE;
            end
        endcase
    end

    // Load at the slot start, shift on every falling bit clock edge.
    assign tx_sh_nxt = !tx_any ? '0 :
                       tx_load ? (fifo_out.valid ? fifo_out.data : '0) :
                       tx_fall ? {tx_sh_r[WORD_BITS-2:0], 1'b0} : tx_sh_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_state_r <= TX_IDLE;
            tx_sh_r <= '0;
        end else begin
            tx_state_r <= tx_state_nxt;
            tx_sh_r <= tx_sh_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive path on the first dual data pin.
    ////////////////////////////////////////////////////////////////////////

    assign rcv_rise = sync_on ? tx_rise : rx_rise;
    assign rcv_word = sync_on ? tx_word : rx_word;
    assign rcv_on = rx_enable & data_rx_sel[0] & pin_func_en[PIN_DATA_LO];
    assign rcv_bit = pin_s[PIN_DATA_LO];

    // A word is only delivered after a full slot seen from its start.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_cnt_r <= CNT_IDLE;
            rx_sh_r <= '0;
            rx_data_r <= '0;
            rx_valid_r <= 1'b0;
        end else begin
            rx_valid_r <= 1'b0;
            if (!rcv_on) begin
                rx_cnt_r <= CNT_IDLE;
            end else if (rcv_word) begin
                rx_cnt_r <= '0;
            end else if (rcv_rise && rx_cnt_r != CNT_IDLE) begin
                rx_sh_r <= {rx_sh_r[WORD_BITS-2:0], rcv_bit};
                rx_cnt_r <= (rx_cnt_r == LAST_BIT) ? CNT_IDLE : rx_cnt_r + 1'b1;
                if (rx_cnt_r == LAST_BIT) begin
                    rx_data_r <= {rx_sh_r[WORD_BITS-2:0], rcv_bit};
                    rx_valid_r <= 1'b1;
                end
            end
        end
    end

    assign rx_data = rx_data_r;
    assign rx_valid = rx_valid_r;

    ////////////////////////////////////////////////////////////////////////
    // Serial function drive of each pin.
    ////////////////////////////////////////////////////////////////////////

    assign fn_oe[PIN_HF_RX] = rx_hf_direction;
    assign fn_o[PIN_HF_RX] = hf_div_r;
    assign fn_oe[PIN_HF_TX] = tx_hf_direction;
    assign fn_o[PIN_HF_TX] = hf_div_r;
    assign fn_oe[PIN_RX_BCK] = rx_clock_direction;
    assign fn_o[PIN_RX_BCK] = sync_on ? of0_r : rx_bck;
    assign fn_oe[PIN_RX_FS] = rx_sync_direction;
    assign fn_o[PIN_RX_FS] = !sync_on ? rx_fs :
                             tx_buffer_enable_select ? tx_active : of1_r;
    assign fn_oe[PIN_TX_BCK] = tx_clock_direction;
    assign fn_o[PIN_TX_BCK] = tx_bck;
    assign fn_oe[PIN_TX_FS] = tx_sync_direction;
    assign fn_o[PIN_TX_FS] = tx_fs;
    assign fn_oe[PIN_TX1] = tx_enable[TX1_IDX];
    assign fn_o[PIN_TX1] = tx_bit;
    assign fn_oe[PIN_TX0] = tx_enable[TX0_IDX];
    assign fn_o[PIN_TX0] = tx_bit;

    for (genvar k = 0; k < N_DUAL; k++) begin : g_dual
        assign fn_oe[PIN_DATA_LO+k] = ~data_rx_sel[k] & tx_enable[N_TX-1-k];
        assign fn_o[PIN_DATA_LO+k] = tx_bit;
    end

    ////////////////////////////////////////////////////////////////////////
    // Function, GPIO and second-port selection per pin.
    ////////////////////////////////////////////////////////////////////////

    assign shared_taken = second_gpio_enable | second_port_enable;

    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        logic own_o;
        logic own_oe;
        logic own_rd;
        assign own_oe = pin_func_en[i] ? fn_oe[i] : gpio_drives(gpio_mode[2*i +: 2]);
        assign own_o = pin_func_en[i] ? fn_o[i] : gpio_out[i];
        assign own_rd = ~pin_func_en[i] & gpio_reads(gpio_mode[2*i +: 2]);
        if (i >= SHARED_LO) begin : g_shared
            localparam int J = i - SHARED_LO;
            assign pin_oe_nxt[i] = second_gpio_enable ?
                                   gpio_drives(sp_gpio_mode[2*J +: 2]) :
                                   second_port_enable ? sp_data_oe[J] : own_oe;
            assign pin_o_nxt[i] = second_gpio_enable ? sp_gpio_out[J] :
                                  second_port_enable ? sp_data_o[J] : own_o;
            assign gpio_in_nxt[i] = own_rd & ~shared_taken & pin_s[i];
        end else begin : g_own
            assign pin_oe_nxt[i] = own_oe;
            assign pin_o_nxt[i] = own_o;
            assign gpio_in_nxt[i] = own_rd & pin_s[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered pin drive and read-back.
    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_o_r <= '0;
            pin_oe_r <= '0;
            gpio_in_r <= '0;
            sp_gpio_in_r <= '0;
            sp_data_i_r <= '0;
        end else begin
            pin_o_r <= pin_o_nxt;
            pin_oe_r <= pin_oe_nxt;
            gpio_in_r <= gpio_in_nxt;
            sp_data_i_r <= second_port_enable & ~second_gpio_enable ?
                           pin_s[SHARED_LO +: N_SHARED] : '0;
            for (int j = 0; j < N_SHARED; j++) begin
                sp_gpio_in_r[j] <= second_gpio_enable &
                                   gpio_reads(sp_gpio_mode[2*j +: 2]) &
                                   pin_s[SHARED_LO+j];
            end
        end
    end

    assign pin_o = pin_o_r;
    assign pin_oe = pin_oe_r;
    assign gpio_in = gpio_in_r;
    assign sp_gpio_in = sp_gpio_in_r;
    assign sp_data_i = sp_data_i_r;

endmodule : audio_serial_port

// [rtl/bit_timing.sv]
`timescale 1ns/10ps
module bit_timing
    import audio_port_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic bck_dir_out,
    input wire logic fs_dir_out,
    input wire logic bck_pin,
    input wire logic fs_pin,
    output logic bck_out,
    output logic fs_out,
    output logic rise,
    output logic fall,
    output logic word_start,
    output logic frame_start
);
    logic [DIV_W-1:0] div_r;
    logic bck_r;
    logic prev_r;
    logic [BIT_W-1:0] bit_r;
    logic [SLOT_W-1:0] slot_r;
    logic fs_smp_r;
    logic fs_old_r;
    logic fs_r;
    logic level;
    logic restart;
    logic wrap;

    // Edges come from the own divider or the synchronised pin.
    assign level = bck_dir_out ? bck_r : bck_pin;
    assign rise = level & ~prev_r;
    assign fall = ~level & prev_r;
    // An external sync seen at a sampling edge restarts slot zero.
    assign restart = ~fs_dir_out & fs_smp_r & ~fs_old_r;
    assign wrap = bit_r == LAST_BIT;
    assign word_start = fall & (restart | wrap);
    assign frame_start = fall & (restart | (wrap & (slot_r == LAST_SLOT)));
    assign bck_out = bck_r;
    assign fs_out = fs_r;

    // Divider, edge history and the bit and slot counters.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= '0;
            bck_r <= 1'b0;
            prev_r <= 1'b0;
            bit_r <= '0;
            slot_r <= '0;
            fs_smp_r <= 1'b0;
            fs_old_r <= 1'b0;
            fs_r <= 1'b0;
        end else begin
            prev_r <= level;
            if (tick) begin
                div_r <= (div_r == LAST_DIV) ? '0 : div_r + 1'b1;
                bck_r <= (div_r == LAST_DIV) ? ~bck_r : bck_r;
            end
            if (rise) begin
                fs_smp_r <= fs_pin;
                fs_old_r <= fs_smp_r;
            end
            if (fall) begin
                fs_r <= frame_start;
                bit_r <= (restart | wrap) ? '0 : bit_r + 1'b1;
                if (restart) begin
                    slot_r <= '0;
                end else if (wrap) begin
                    slot_r <= (slot_r == LAST_SLOT) ? '0 : slot_r + 1'b1;
                end
            end
        end
    end
endmodule : bit_timing

// [rtl/stream_if.sv]
`timescale 1ns/10ps
// Valid/ready word stream between the port logic and its buffer.
interface stream_if #(parameter int WIDTH = 24);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface : stream_if

// [rtl/word_fifo.sv]
`timescale 1ns/10ps
module word_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic nrst,
    stream_if.snk in_s,
    stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] count_r;
    logic ov_r;
    logic [WIDTH-1:0] od_r;
    logic push;
    logic load;
    logic drain;

    // The output register adds one word of slack beyond the memory.
    assign in_s.ready = count_r != CNT_FULL;
    assign push = in_s.valid & in_s.ready;
    assign drain = ov_r & out_s.ready;
    assign load = (count_r != '0) & (~ov_r | out_s.ready);
    assign out_s.valid = ov_r;
    assign out_s.data = od_r;

    // Storage holds no reset so it maps onto plain memory.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_s.data;
        end
    end

    // Pointers, fill count and the registered read word.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_r <= '0;
            rp_r <= '0;
            count_r <= '0;
            ov_r <= 1'b0;
            od_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (load) begin
                od_r <= mem[rp_r];
                rp_r <= rp_r + 1'b1;
                ov_r <= 1'b1;
            end else if (drain) begin
                ov_r <= 1'b0;
            end
            if (push & ~load) begin
                count_r <= count_r + 1'b1;
            end else if (load & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule : word_fifo
